// ==== dv/tec_pin_model.sv ====
// pulse source standing in for the timer input pin
`timescale 1ns/1ps
module tec_pin_model
(
   input  wire logic        clk_sys,
   input  wire logic        pulse_go,
   input  wire logic [15:0] pulse_len,
   input  wire logic        idle_lvl,
   output logic             timer_ext_input_pin
);
   logic [15:0] left_reg = 16'h0000;
   // pin leaves its idle level for pulse_len clocks, then returns to it
   always_ff @(posedge clk_sys)
   begin
      if (pulse_go)
         left_reg <= pulse_len;
      else if (left_reg != 16'h0000)
         left_reg <= left_reg - 16'h0001;
   end
   assign timer_ext_input_pin = idle_lvl ^ (left_reg != 16'h0000);
endmodule : tec_pin_model

// ==== dv/test_tec_timer.sv ====
// self-checking bench for the sixteen bit event timer
`timescale 1ns/1ps
module test_tec_timer;
   localparam logic [4:0] HI = tec_pkg::TEC_IDX_CNT_HI;
   localparam logic [4:0] LO = tec_pkg::TEC_IDX_CNT_LO;
   localparam logic [4:0] CT = tec_pkg::TEC_IDX_CTRL;
   localparam logic [4:0] IC = tec_pkg::TEC_IDX_INTERRUPT_CONTROL_REG;
   logic        clk_sys = 1'b0;
   logic        rstn = 1'b0;
   logic [6:0]  avs_address = 7'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h00000000;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pin;
   logic        irq_ack = 1'b0;
   logic        irq_reg;
   logic        wake_reg;
   logic        pulse_go = 1'b0;
   logic [15:0] pulse_len = 16'h0000;
   logic        idle_lvl = 1'b0;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          irq_seen = 0;
   logic [7:0]  rd;
   logic [15:0] cnt;
   logic [15:0] cnt2;

   always #2 clk_sys = ~clk_sys;
   always @(negedge clk_sys)
      if (irq_reg === 1'b1)
         irq_seen++;

   tec_timer tec_timer_i (.clk_sys(clk_sys), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .timer_ext_input_pin(pin), .irq_ack(irq_ack),
      .irq_reg(irq_reg), .wake_reg(wake_reg));
   tec_pin_model tec_pin_model_i (.clk_sys(clk_sys), .pulse_go(pulse_go),
      .pulse_len(pulse_len), .idle_lvl(idle_lvl),
      .timer_ext_input_pin(pin));

   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input string what, input logic [15:0] lo, hi, got);
      n_compared++;
      if (!(got >= lo && got <= hi) || $isunknown(got))
      begin
         error_cnt++;
         $display("mismatch %s expected %h..%h seen %h", what, lo, hi, got);
      end
   endtask : chk

   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr_en, input logic [4:0] idx,
                      input logic [7:0] wd, output logic [7:0] rdv);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_address <= {idx, 2'b00};
      avs_writedata <= {24'h000000, wd};
      avs_write <= wr_en;
      avs_read <= ~wr_en;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 20)
      begin
         @(posedge clk_sys);
         n++;
      end
      if (avs_waitrequest !== 1'b0)
      begin
         error_cnt++;
         $display("mismatch waitrequest expected 0 seen 1");
         finish_test();
      end
      rdv = avs_readdata[7:0];
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask : bus

   task automatic wr(input logic [4:0] idx, input logic [7:0] d);
      logic [7:0] dummy;
      bus(1'b1, idx, d, dummy);
   endtask : wr

   task automatic rdb(input logic [4:0] idx, output logic [7:0] d);
      bus(1'b0, idx, 8'h00, d);
   endtask : rdb

   // high byte first so the low byte comes from the latched copy
   task automatic rd_cnt(output logic [15:0] c);
      logic [7:0] h;
      logic [7:0] l;
      rdb(HI, h);
      rdb(LO, l);
      c = {h, l};
   endtask : rd_cnt

   task automatic pulse(input logic [15:0] len, input int settle);
      @(posedge clk_sys);
      pulse_go <= 1'b1;
      pulse_len <= len;
      @(posedge clk_sys);
      pulse_go <= 1'b0;
      repeat (settle) @(posedge clk_sys);
   endtask : pulse

   task automatic wait_wake;
      int n;
      n = 0;
      while (wake_reg !== 1'b1 && n < 400)
      begin
         @(negedge clk_sys);
         n++;
      end
      chk("wake", 16'h0001, 16'h0001, {15'h0, wake_reg});
      if (wake_reg !== 1'b1)
         finish_test();
   endtask : wait_wake

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rstn <= 1'b1;
      rdb(CT, rd); chk("ctrl rst", 8'h00, 8'h00, rd);
      rdb(IC, rd); chk("interrupt_control_reg rst", 8'h00, 8'h00, rd);
      rdb(5'h13, rd); chk("unmapped", 8'h00, 8'h00, rd);
      wr(CT, 8'hEF);
      rdb(CT, rd); chk("ctrl bits", 8'hC8, 8'hC8, rd);
      $display("test registers done");
      wr(CT, 8'h00);
      wr(LO, 8'h34);
      wr(HI, 8'h12);
      rd_cnt(cnt); chk("preload copy", 16'h1234, 16'h1234, cnt);
      wr(LO, 8'h99);
      rd_cnt(cnt); chk("low buffered", 16'h1234, 16'h1234, cnt);
      wr(CT, 8'h10);
      repeat (40) @(posedge clk_sys);
      rd_cnt(cnt); chk("mode off", 16'h1234, 16'h1234, cnt);
      wr(CT, 8'h80);
      repeat (40) @(posedge clk_sys);
      rd_cnt(cnt); chk("enable off", 16'h1234, 16'h1234, cnt);
      $display("test preload done");
      // overflow with the interrupt masked, new preload while running
      wr(IC, 8'h00);
      wr(LO, 8'hF0);
      wr(HI, 8'hFF);
      wr(CT, 8'h90);
      wr(LO, 8'h00);
      wr(HI, 8'h10);
      wait_wake();
      rdb(CT, rd); chk("enable kept", 8'h90, 8'h90, rd);
      wr(CT, 8'h80);
      rd_cnt(cnt); chk("reload", 16'h1000, 16'h10FF, cnt);
      rdb(IC, rd); chk("flag set", 8'h40, 8'h40, rd);
      chk("irq masked", 16'h0, 16'h0, 16'(irq_seen));
      wr(IC, 8'h41);
      repeat (3) @(posedge clk_sys);
      chk("irq on", 16'h1, 16'h1, {15'h0, irq_reg});
      irq_ack <= 1'b1;
      @(posedge clk_sys);
      irq_ack <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk("irq off", 16'h0, 16'h0, {15'h0, irq_reg});
      rdb(IC, rd); chk("flag clear", 8'h01, 8'h01, rd);
      $display("test overflow done");
      wr(LO, 8'h00);
      wr(HI, 8'h00);
      wr(CT, 8'h50);
      repeat (3) pulse(16'd10, 20);
      rd_cnt(cnt); chk("events", 16'h0003, 16'h0003, cnt);
      wr(CT, 8'h58);
      pulse(16'd200, 60);
      rd_cnt(cnt); chk("no rise count", 16'h3, 16'h3, cnt);
      repeat (180) @(posedge clk_sys);
      rd_cnt(cnt); chk("fall count", 16'h4, 16'h4, cnt);
      wr(CT, 8'h40);
      $display("test events done");
      wr(LO, 8'h00);
      wr(HI, 8'h00);
      idle_lvl <= 1'b1;
      repeat (10) @(posedge clk_sys);
      wr(CT, 8'hD0);
      repeat (60) @(posedge clk_sys);
      rd_cnt(cnt); chk("level no start", 16'h0, 16'h0, cnt);
      idle_lvl <= 1'b0;
      repeat (10) @(posedge clk_sys);
      pulse(16'd40, 50);
      rd_cnt(cnt); chk("width", 16'd9, 16'd11, cnt);
      rdb(CT, rd); chk("auto clear", 8'hC0, 8'hC0, rd);
      pulse(16'd40, 50);
      rd_cnt(cnt2); chk("held", cnt, cnt, cnt2);
      wr(CT, 8'hD0);
      pulse(16'd80, 90);
      rd_cnt(cnt2); chk("rearm", cnt + 16'd19, cnt + 16'd21, cnt2);
      // overflow inside a measurement reloads and raises the flag
      wr(IC, 8'h00);
      wr(LO, 8'hFC);
      wr(HI, 8'hFF);
      wr(CT, 8'hD0);
      pulse(16'd40, 50);
      rd_cnt(cnt); chk("pw reload", 16'hFFFD, 16'hFFFF, cnt);
      rdb(IC, rd); chk("pw flag", 8'h40, 8'h40, rd);
      $display("test pulse width done");
      finish_test();
   end
endmodule : test_tec_timer

// ==== rtl/tec_pkg.sv ====
// constants shared by the sixteen bit event timer
package tec_pkg;
   // register word indices; byte address is four times the index
   localparam logic [4:0] TEC_IDX_CNT_HI = 5'h0F;
   localparam logic [4:0] TEC_IDX_CNT_LO = 5'h10;
   localparam logic [4:0] TEC_IDX_CTRL   = 5'h11;
   localparam logic [4:0] TEC_IDX_INTERRUPT_CONTROL_REG   = 5'h12;
   // control register fields
   localparam int TEC_CTRL_EDGE_BIT = 3;
   localparam int TEC_CTRL_EN_BIT   = 4;
   localparam int TEC_CTRL_MODE_LSB = 6;
   // interrupt control fields
   localparam int TEC_INTERRUPT_CONTROL_REG_IE_BIT   = 0;
   localparam int TEC_INTERRUPT_CONTROL_REG_FLAG_BIT = 6;
   // reset values and counter maximum
   localparam logic [7:0]  TEC_CTRL_RST  = 8'h00;
   localparam logic [15:0] TEC_CNT_RST   = 16'h0000;
   localparam logic [15:0] TEC_CNT_MAX   = 16'hFFFF;
   // mode field encodings
   localparam logic [1:0] TEC_MODE_OFF = 2'h0;
   localparam logic [1:0] TEC_MODE_EVT = 2'h1;
   localparam logic [1:0] TEC_MODE_TMR = 2'h2;
   localparam logic [1:0] TEC_MODE_PW  = 2'h3;
   // system clocks per instruction clock
   localparam int TEC_INSTR_DIV = 4;
   typedef enum logic [1:0]
   {
      TEC_PW_WAIT = 2'b01,
      TEC_PW_MEAS = 2'b10
   } tec_pw_e;
endpackage : tec_pkg

// ==== rtl/tec_sync3.sv ====
// three stage pin synchroniser with registered edge pulses
`timescale 1ns/1ps
module tec_sync3
(
   input  wire logic clk_sys,
   input  wire logic rstn,
   input  wire logic pin_in,
   output logic      rise_reg,
   output logic      fall_reg
);
   logic s1_reg;
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts only once the second and third stages agree
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         lvl_reg  <= 1'b0;
         rise_reg <= 1'b0;
         fall_reg <= 1'b0;
      end
      else
      begin
         rise_reg <= (s2_reg == s3_reg) && s3_reg && !lvl_reg;
         fall_reg <= (s2_reg == s3_reg) && !s3_reg && lvl_reg;
         if (s2_reg == s3_reg)
         begin
            lvl_reg <= s3_reg;
         end
      end
   end
endmodule : tec_sync3

// ==== rtl/tec_timer.sv ====
// sixteen bit timer and event counter with avalon register slave
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
module tec_timer
#(
   parameter int INSTR_DIV = tec_pkg::TEC_INSTR_DIV
)
(
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   input  wire logic [6:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        timer_ext_input_pin,
   input  wire logic        irq_ack,
   output logic             irq_reg,
   output logic             wake_reg
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0]          cnt_reg;
   logic [15:0]          preload_reg;
   logic [7:0]           low_buf_reg;
   logic [1:0]           mode_reg;
   logic                 edge_sel_reg;
   logic                 en_reg;
   logic                 flag_reg;
   logic                 ie_reg;
   logic                 wait_reg;
   logic [31:0]          rdata_reg;
   logic [7:0]           div_reg;
   logic                 tick_reg;
   tec_pkg::tec_pw_e     pw_reg;
   logic                 pin_rise;
   logic                 pin_fall;
   logic [4:0]           idx;
   logic                 acc;
   logic                 wacc;
   logic                 wr_hi;
   logic                 wr_lo;
   logic                 wr_ctrl;
   logic                 wr_interrupt_control_reg;
   logic                 rd_hi;
   logic                 blk;
   logic                 act_edge;
   logic                 end_edge;
   logic                 inc;
   logic                 ovf;
   logic                 pw_done;
   logic [7:0]           ctrl_rd;

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;

   ////////////////////////////////////////////////////////////////////////
   // bus decode; a read is loaded on the edge where waitrequest drops
   assign idx     = avs_address[6:2];
   assign acc     = wait_reg && (avs_read || avs_write);
   // writes land only on the edge where the master sees waitrequest low
   assign wacc    = !wait_reg && avs_write;
   assign wr_hi   = wacc && idx == tec_pkg::TEC_IDX_CNT_HI;
   assign wr_lo   = wacc && idx == tec_pkg::TEC_IDX_CNT_LO;
   assign wr_ctrl = wacc && idx == tec_pkg::TEC_IDX_CTRL;
   assign wr_interrupt_control_reg = wacc && idx == tec_pkg::TEC_IDX_INTERRUPT_CONTROL_REG;
   assign rd_hi   = acc && avs_read && idx == tec_pkg::TEC_IDX_CNT_HI;
   // the whole high byte read, both cycles, holds the count still
   assign blk     = avs_read && idx == tec_pkg::TEC_IDX_CNT_HI;

   assign ctrl_rd = {mode_reg, 1'b0, en_reg, edge_sel_reg, 3'h0};

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         wait_reg <= 1'b1;
      end
      else
      begin
         wait_reg <= !acc;
      end
   end

   // unmapped reads return zero and unmapped writes are dropped
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         rdata_reg <= 32'h0000_0000;
      end
      else if (acc && avs_read)
      begin
         case (idx)
            tec_pkg::TEC_IDX_CNT_HI: rdata_reg <= {24'h0, cnt_reg[15:8]};
            tec_pkg::TEC_IDX_CNT_LO: rdata_reg <= {24'h0, low_buf_reg};
            tec_pkg::TEC_IDX_CTRL:   rdata_reg <= {24'h0, ctrl_rd};
            tec_pkg::TEC_IDX_INTERRUPT_CONTROL_REG:   rdata_reg <= {24'h0, 1'b0, flag_reg,
                                                   5'h0, ie_reg};
            default:                 rdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // low byte buffer is shared by the write path and the read latch
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         low_buf_reg <= 8'h00;
      end
      else if (wr_lo)
      begin
         low_buf_reg <= avs_writedata[7:0];
      end
      else if (rd_hi)
      begin
         low_buf_reg <= cnt_reg[7:0];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         preload_reg <= tec_pkg::TEC_CNT_RST;
      end
      else if (wr_hi)
      begin
         preload_reg <= {avs_writedata[7:0], low_buf_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control register; software write wins over the automatic clear
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         mode_reg     <= tec_pkg::TEC_CTRL_RST[7:6];
         edge_sel_reg <= tec_pkg::TEC_CTRL_RST[3];
         en_reg       <= tec_pkg::TEC_CTRL_RST[4];
      end
      else if (wr_ctrl)
      begin
         mode_reg     <= avs_writedata[tec_pkg::TEC_CTRL_MODE_LSB +: 2];
         edge_sel_reg <= avs_writedata[tec_pkg::TEC_CTRL_EDGE_BIT];
         en_reg       <= avs_writedata[tec_pkg::TEC_CTRL_EN_BIT];
      end
      else if (pw_done)
      begin
         en_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // instruction clock tick
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b0;
      end
      else if (div_reg == 8'(INSTR_DIV - 1))
      begin
         div_reg  <= 8'h00;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg  <= div_reg + 8'h01;
         tick_reg <= 1'b0;
      end
   end

   tec_sync3 u_sync
   (
      .clk_sys  (clk_sys),
      .rstn     (rstn),
      .pin_in   (timer_ext_input_pin),
      .rise_reg (pin_rise),
      .fall_reg (pin_fall)
   );

   assign act_edge = edge_sel_reg ? pin_fall : pin_rise;
   assign end_edge = edge_sel_reg ? pin_rise : pin_fall;

   ////////////////////////////////////////////////////////////////////////
   // pulse width sequencer; an armed input already high waits for an edge
   assign pw_done = en_reg && mode_reg == tec_pkg::TEC_MODE_PW &&
                    pw_reg == tec_pkg::TEC_PW_MEAS && end_edge;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         pw_reg <= tec_pkg::TEC_PW_WAIT;
      end
      else if (!(en_reg && mode_reg == tec_pkg::TEC_MODE_PW))
      begin
         pw_reg <= tec_pkg::TEC_PW_WAIT;
      end
      else
      begin
         case (pw_reg)
            tec_pkg::TEC_PW_WAIT:
            begin
               if (act_edge)
               begin
                  pw_reg <= tec_pkg::TEC_PW_MEAS;
               end
            end
            tec_pkg::TEC_PW_MEAS:
            begin
               if (end_edge)
               begin
                  pw_reg <= tec_pkg::TEC_PW_WAIT;
               end
            end
            default: pw_reg <= tec_pkg::TEC_PW_WAIT;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter; mode 00 never counts
   always_comb
   begin
      case (mode_reg)
         tec_pkg::TEC_MODE_EVT: inc = act_edge;
         tec_pkg::TEC_MODE_TMR: inc = tick_reg;
         tec_pkg::TEC_MODE_PW:
            inc = tick_reg && pw_reg == tec_pkg::TEC_PW_MEAS;
         default:               inc = 1'b0;
      endcase
      inc = inc && en_reg && !blk;
   end

   assign ovf = inc && cnt_reg == tec_pkg::TEC_CNT_MAX;

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         cnt_reg <= tec_pkg::TEC_CNT_RST;
      end
      else if (wr_hi && !en_reg)
      begin
         cnt_reg <= {avs_writedata[7:0], low_buf_reg};
      end
      else if (ovf)
      begin
         cnt_reg <= preload_reg;
      end
      else if (inc)
      begin
         cnt_reg <= cnt_reg + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // overflow flag: a set in the clearing cycle is kept
   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         flag_reg <= 1'b0;
         ie_reg   <= 1'b0;
      end
      else
      begin
         if (ovf)
         begin
            flag_reg <= 1'b1;
         end
         else if (irq_ack)
         begin
            flag_reg <= 1'b0;
         end
         else if (wr_interrupt_control_reg)
         begin
            flag_reg <= avs_writedata[tec_pkg::TEC_INTERRUPT_CONTROL_REG_FLAG_BIT];
         end
         if (wr_interrupt_control_reg)
         begin
            ie_reg <= avs_writedata[tec_pkg::TEC_INTERRUPT_CONTROL_REG_IE_BIT];
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rstn)
      begin
         irq_reg  <= 1'b0;
         wake_reg <= 1'b0;
      end
      else
      begin
         irq_reg  <= flag_reg && ie_reg;
         wake_reg <= ovf;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence s_ovf;
      inc && cnt_reg == 16'hFFFF;
   endsequence

   sequence s_load_off;
      avs_write && !wait_reg && !en_reg &&
      avs_address[6:2] == tec_pkg::TEC_IDX_CNT_HI;
   endsequence

   a_ovf_reload: assert property (s_ovf |=> cnt_reg == $past(preload_reg))
      else $error("counter did not reload on overflow");
   a_ovf_flag: assert property (s_ovf |=> flag_reg)
      else $error("overflow flag not set");
   a_wake_pulse: assert property (s_ovf |=>
      wake_reg ##1 (!wake_reg || $past(ovf)))
      else $error("wake pulse missing after overflow");
   a_ctrl_zero: assert property (avs_read && !wait_reg &&
      avs_address[6:2] == tec_pkg::TEC_IDX_CTRL |->
      avs_readdata[2:0] == 3'h0 && !avs_readdata[5])
      else $error("unused control bits read nonzero");
   a_hold_off: assert property (!en_reg && !avs_write |=> $stable(cnt_reg))
      else $error("counter moved while disabled");
   a_en_kept: assert property (en_reg && mode_reg != 2'h3 && !wr_ctrl
      |=> en_reg)
      else $error("enable cleared without software");
   a_pw_stop: assert property (pw_done && !wr_ctrl |=> !en_reg ##1 $stable(cnt_reg))
      else $error("measurement did not stop");
   a_read_block: assert property (avs_read &&
      avs_address[6:2] == tec_pkg::TEC_IDX_CNT_HI |=> $stable(cnt_reg))
      else $error("counter moved during high byte read");
   a_irq_gate: assert property (!ie_reg |=> !irq_reg)
      else $error("interrupt raised while disabled");
   a_load_copy: assert property (s_load_off |=>
      cnt_reg == {$past(avs_writedata[7:0]), $past(low_buf_reg)})
      else $error("preload write not copied to idle counter");
endmodule : tec_timer
